// File: hw/otg_boost_enable_fault_ctl.sv
// Boost and isolation switch control with register file and fault flag
`timescale 1ns/10ps
module otg_boost_enable_fault_ctl #(
  parameter int SOFT_START_CYCLES = obf_pkg::SOFT_START_CYCLES
) (
  // Clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rst_b,
  // Parallel host register port
  input  wire logic [obf_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  input  wire logic [obf_pkg::DATA_W-1:0] reg_wdata,
  output logic      [obf_pkg::DATA_W-1:0] reg_rdata,
  // Charger control bits
  input  wire logic                       charger_direction_bit,
  input  wire logic                       connector_feed_n,
  // Standby exit
  input  wire logic                       standby_exit_pin,
  // Comparators on the boost feedback pin
  input  wire logic                       uv_below,
  input  wire logic                       uv_above_hyst,
  input  wire logic                       out_steady,
  input  wire logic                       oc_detect,
  input  wire logic                       sc_detect,
  input  wire logic                       ov_detect,
  // Bus presence detection
  input  wire logic                       bus_presence_raw,
  output logic                            bus_presence_irq,
  // Power stage controls
  output logic                            boost_en,
  output logic                            iso_switch_en,
  output logic                            switch_fet_off,
  output logic                            uv_comp_en,
  output logic                            discharge_en,
  output logic                            soft_start_active,
  // Fault
  output logic                            boost_fault_flag
);
  localparam int FW = obf_pkg::FIELD_W;
  localparam int DW = obf_pkg::DATA_W;

  if (SOFT_START_CYCLES < 1) begin : g_bad_soft_start
    $error("SOFT_START_CYCLES must be at least one");
  end

  typedef struct packed {
    logic          dsch_dis;
    logic [FW-1:0] state_field;
    logic [FW-1:0] stby_field;
    logic          stby_pin;
    logic          boost_en;
    logic          iso_en;
    logic          fet_off;
    logic          uv_comp;
    logic          discharge;
    logic          bus_irq;
    logic [DW-1:0] rdata;
  } obf_ctl_state_t;

  obf_ctl_state_t s_q;
  obf_ctl_state_t s_d;

  obf_fault_if fi ();

  logic wr_dsch;
  logic wr_state;
  logic stby_edge;
  logic stby_copy;
  logic host_feed;
  logic want_on;
  logic shut;
  logic boost_next;
  logic iso_next;
  logic ss_active;
  logic [FW-1:0] wr_state_field;
  logic [FW-1:0] wr_stby_field;

  // Register decode
  always_comb begin
    wr_dsch        = reg_wr & (reg_addr == obf_pkg::DSCH_CTL_OFFSET);
    wr_state       = reg_wr & (reg_addr == obf_pkg::STATE_CTL_OFFSET);
    wr_state_field = reg_wdata[obf_pkg::STATE_FIELD_LSB +: FW];
    wr_stby_field  = reg_wdata[obf_pkg::STBY_FIELD_LSB +: FW];
  end

  // Standby exit copy on rising edge
  always_comb begin
    stby_edge = standby_exit_pin & ~s_q.stby_pin;
    stby_copy = stby_edge
              & ((s_q.stby_field == obf_pkg::STATE_OFF)
              |  (s_q.stby_field == obf_pkg::STATE_ON));               // [R11]
  end

  // On/off decision
  always_comb begin
    host_feed  = charger_direction_bit & ~connector_feed_n;           // [R2]
    want_on    = host_feed
               | (s_d.state_field == obf_pkg::STATE_ON);              // [R1] [R3] [R10]
    shut       = fi.sc_latch | fi.ov_latch;                            // [R7] [R9]
    boost_next = want_on & ~shut;
    iso_next   = host_feed & ~shut;                                    // [R1] [R3] [R7]
  end

  // Next state
  always_comb begin
    s_d          = s_q;
    s_d.stby_pin = standby_exit_pin;
    if (wr_dsch) begin
      s_d.dsch_dis = reg_wdata[obf_pkg::DSCH_DIS_BIT];
    end
    if (wr_state) begin
      s_d.state_field = wr_state_field;
      s_d.stby_field  = wr_stby_field;
    end
    // Pin copy takes priority over a same-cycle write
    if (stby_copy) begin
      s_d.state_field = s_q.stby_field;                                // [R11]
    end
    s_d.boost_en  = 1'h0;
    s_d.iso_en    = 1'h0;
    s_d.fet_off   = 1'h0;
    s_d.uv_comp   = 1'h0;
    s_d.discharge = 1'h0;
    s_d.bus_irq   = 1'h0;
    s_d.rdata     = s_q.rdata;
  end

  // Outputs of the power stage and read data
  obf_ctl_state_t o_d;

  always_comb begin
    o_d           = s_d;
    o_d.boost_en  = boost_next;
    o_d.iso_en    = iso_next;
    o_d.fet_off   = boost_next & oc_detect;                            // [R6]
    o_d.uv_comp   = boost_next;                                        // [R4]
    o_d.discharge = ~s_d.dsch_dis & ~boost_next;                       // [R12]
    o_d.bus_irq   = bus_presence_raw & ~host_feed;                     // [R14]
    if (reg_rd) begin
      if (reg_addr == obf_pkg::DSCH_CTL_OFFSET) begin
        o_d.rdata = {{(DW-1){1'h0}}, s_q.dsch_dis};
      end else if (reg_addr == obf_pkg::STATE_CTL_OFFSET) begin
        o_d.rdata = {2'h0, s_q.stby_field, s_q.state_field};
      end else begin
        o_d.rdata = '0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q             <= '0;
      s_q.dsch_dis    <= obf_pkg::DSCH_CTL_RESET[obf_pkg::DSCH_DIS_BIT];       // [R12]
      s_q.state_field <= obf_pkg::STATE_CTL_RESET[obf_pkg::STATE_FIELD_LSB +: FW];
      s_q.stby_field  <= obf_pkg::STATE_CTL_RESET[obf_pkg::STBY_FIELD_LSB +: FW];
    end else begin
      s_q <= o_d;
    end
  end

  // Fault tracker hookup
  assign fi.boost_on      = s_q.boost_en;
  assign fi.turn_on       = boost_next & ~s_q.boost_en;                // [R4]
  assign fi.reenable      = wr_state & (wr_state_field == obf_pkg::STATE_ON); // [R7] [R9]
  assign fi.soft_start    = ss_active;                                 // [R8]
  assign fi.uv_below      = uv_below;
  assign fi.uv_above_hyst = uv_above_hyst;
  assign fi.steady        = out_steady;
  assign fi.oc            = oc_detect;
  assign fi.sc            = sc_detect;
  assign fi.ov            = ov_detect;

  obf_soft_start #(
    .CYCLES (SOFT_START_CYCLES)
  ) u_soft_start (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .start    (boost_next & ~s_q.boost_en),                            // [R8]
    .abort    (~boost_next),
    .active   (ss_active)
  );

  obf_fault_track u_fault (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .f        (fi.fault)
  );

  assign reg_rdata         = s_q.rdata;
  assign boost_en          = s_q.boost_en;
  assign iso_switch_en     = s_q.iso_en;
  assign switch_fet_off    = s_q.fet_off;
  assign uv_comp_en        = s_q.uv_comp;
  assign discharge_en      = s_q.discharge;
  assign bus_presence_irq  = s_q.bus_irq;
  assign soft_start_active = ss_active;
  assign boost_fault_flag  = fi.fault_flag;                            // [R15]
endmodule

// File: hw/obf_pkg.sv
// Constants, register map and field layout of the boost enable and fault control
// Notes on behaviour
// (R1) Direction clear: switch off, boost follows field
// (R2) Direction set, feed low: boost and switch on
// (R3) Direction set, feed high: switch off, field rules
// (R4) Turn-on raises flag until output steady
// (R5) Under-voltage sets flag, hysteresis level clears it
// (R6) Over-current: FET off, flag while current high
// (R7) Short: boost and switch off, latched
// (R8) Short detection masked during soft start
// (R9) Over-voltage: shutdown, latched until re-enable
// (R10) State field: 4 off, 7 on, others idle
// (R11) Standby exit copies field 4 or 7 only
// (R12) Discharge bit 0 enables, resets to 1
// (R13) Software sets discharge bit without isolation switch
// (R14) Host mode masks bus presence interrupt
// (R15) Fault flag is OR of all faults
package obf_pkg;
  localparam int          ADDR_W            = 9;
  localparam int          DATA_W            = 8;
  localparam int          FIELD_W           = 3;
  localparam logic [8:0]  DSCH_CTL_OFFSET   = 9'h1c5;
  localparam logic [8:0]  STATE_CTL_OFFSET  = 9'h1c6;
  localparam logic [7:0]  DSCH_CTL_RESET    = 8'h01;
  localparam logic [7:0]  STATE_CTL_RESET   = 8'h24;
  localparam int          DSCH_DIS_BIT      = 0;
  localparam int          STATE_FIELD_LSB   = 0;
  localparam int          STBY_FIELD_LSB    = 3;
  localparam logic [2:0]  STATE_OFF         = 3'h4;
  localparam logic [2:0]  STATE_ON          = 3'h7;
  localparam int          SOFT_START_US     = 4000;
  localparam int          CLK_KHZ           = 10000;
  localparam int          SOFT_START_CYCLES = (SOFT_START_US * CLK_KHZ + 999) / 1000;
endpackage

// File: hw/obf_fault_if.sv
// Signals between the boost control and its fault tracker
`timescale 1ns/10ps
interface obf_fault_if;
  logic boost_on;
  logic turn_on;
  logic reenable;
  logic soft_start;
  logic uv_below;
  logic uv_above_hyst;
  logic steady;
  logic oc;
  logic sc;
  logic ov;
  logic uv_fault;
  logic oc_fault;
  logic sc_latch;
  logic ov_latch;
  logic fault_flag;
  modport fault (input  boost_on, turn_on, reenable, soft_start, uv_below,
                 uv_above_hyst, steady, oc, sc, ov,
                 output uv_fault, oc_fault, sc_latch, ov_latch, fault_flag);
  modport ctl   (output boost_on, turn_on, reenable, soft_start, uv_below,
                 uv_above_hyst, steady, oc, sc, ov,
                 input  uv_fault, oc_fault, sc_latch, ov_latch, fault_flag);
endinterface

// File: hw/obf_soft_start.sv
// Soft-start window timer
`timescale 1ns/10ps
module obf_soft_start #(
  parameter int CYCLES = obf_pkg::SOFT_START_CYCLES
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_b,
  // Control
  input  wire logic start,
  input  wire logic abort,
  // Status
  output logic      active
);
  localparam int CW = $clog2(CYCLES + 1);

  if (CYCLES < 1) begin : g_bad_cycles
    $error("CYCLES must be at least one");
  end

  typedef struct packed {
    logic          active;
    logic [CW-1:0] cnt;
  } obf_ss_state_t;

  obf_ss_state_t s_q;
  obf_ss_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (abort) begin
      s_d.active = 1'h0;
      s_d.cnt    = '0;
    end else if (start) begin
      s_d.active = 1'h1;
      s_d.cnt    = CW'(CYCLES - 1);
    end else if (s_q.active) begin
      if (s_q.cnt == '0) begin
        s_d.active = 1'h0;
      end else begin
        s_d.cnt = s_q.cnt - CW'(1);
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign active = s_q.active;
endmodule

// File: hw/obf_fault_track.sv
// Fault condition tracking and combined fault flag
`timescale 1ns/10ps
module obf_fault_track (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Fault signals
  obf_fault_if.fault f
);
  typedef struct packed {
    logic uv;
    logic oc;
    logic sc;
    logic ov;
    logic flag;
  } obf_ft_state_t;

  obf_ft_state_t s_q;
  obf_ft_state_t s_d;
  logic          uv_set;
  logic          uv_clr;

  always_comb begin
    s_d    = s_q;
    uv_set = f.turn_on | (f.boost_on & f.uv_below);                    // [R4] [R5]
    uv_clr = ~f.boost_on | f.steady | f.uv_above_hyst;                 // [R4] [R5]
    s_d.uv = (s_q.uv & ~uv_clr) | uv_set;
    s_d.oc = f.oc & f.boost_on;                                        // [R6]
    s_d.sc = (s_q.sc & ~f.reenable)
           | (f.sc & f.boost_on & ~f.soft_start);                      // [R7] [R8]
    s_d.ov = (s_q.ov & ~f.reenable) | (f.ov & f.boost_on);             // [R9]
    s_d.flag = s_d.uv | s_d.oc | s_d.sc | s_d.ov;                      // [R15]
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign f.uv_fault   = s_q.uv;
  assign f.oc_fault   = s_q.oc;
  assign f.sc_latch   = s_q.sc;
  assign f.ov_latch   = s_q.ov;
  assign f.fault_flag = s_q.flag;
endmodule

// File: dv/obf_checker.sv
// Port assertions for the boost enable and fault control
`timescale 1ns/10ps
module obf_checker #(
  parameter int SOFT_START_CYCLES = obf_pkg::SOFT_START_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Stimulus side
  input wire logic charger_direction_bit,
  input wire logic connector_feed_n,
  input wire logic uv_below,
  input wire logic oc_detect,
  input wire logic sc_detect,
  input wire logic ov_detect,
  input wire logic bus_presence_raw,
  // Controlled side
  input wire logic bus_presence_irq,
  input wire logic boost_en,
  input wire logic iso_switch_en,
  input wire logic switch_fet_off,
  input wire logic uv_comp_en,
  input wire logic discharge_en,
  input wire logic soft_start_active,
  input wire logic boost_fault_flag
);
  logic [15:0] ss_cnt_q;
  logic [15:0] ss_cnt_d;
  logic        boost_q;
  // Window length counted from the latest turn-on
  assign ss_cnt_d = !soft_start_active ? 16'h0 : (boost_en && !boost_q) ? 16'h1 : ss_cnt_q + 16'h1;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ss_cnt_q <= 16'h0;
      boost_q  <= 1'h0;
    end else begin
      ss_cnt_q <= ss_cnt_d;
      boost_q  <= boost_en;
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  AST_ISO: assert property (iso_switch_en |-> $past(charger_direction_bit)
    && !$past(connector_feed_n)) else $error("switch on without host feed");
  AST_FEED: assert property (iso_switch_en |-> boost_en)
    else $error("switch on with boost off");
  AST_TURN_ON: assert property ($rose(boost_en) |-> boost_fault_flag)
    else $error("no flag at turn-on");
  AST_UVC: assert property (uv_comp_en == boost_en)
    else $error("comparator enable wrong");
  AST_UV: assert property (boost_en && uv_below |=> boost_fault_flag)
    else $error("under-voltage not flagged");
  AST_OC_FET: assert property (switch_fet_off |-> $past(oc_detect))
    else $error("switch off without over-current");
  AST_OC: assert property (boost_en && oc_detect |=> boost_fault_flag)
    else $error("over-current not flagged");
  AST_SC: assert property ($past(boost_en) && boost_en && !soft_start_active && sc_detect
    |-> ##[1:2] (!boost_en && !iso_switch_en && boost_fault_flag)) else $error("short not tripped");
  AST_SS_LEN: assert property ($fell(soft_start_active) && boost_en
    |-> ss_cnt_q == SOFT_START_CYCLES) else $error("soft start length wrong");
  AST_OV: assert property (boost_en && ov_detect |-> ##[1:2] (!boost_en && boost_fault_flag))
    else $error("over-voltage not tripped");
  AST_DSCH: assert property (discharge_en |-> !boost_en || $rose(boost_en))
    else $error("discharge while boost on");
  AST_IRQ: assert property (bus_presence_irq |-> $past(bus_presence_raw)
    && !($past(charger_direction_bit) && !$past(connector_feed_n))) else $error("irq not masked");
  cover property ($rose(iso_switch_en));
  cover property ($fell(soft_start_active) && boost_en);
  cover property ($rose(switch_fet_off));
  cover property ($rose(bus_presence_irq));
endmodule
bind otg_boost_enable_fault_ctl obf_checker #(.SOFT_START_CYCLES(SOFT_START_CYCLES)) u_chk (
  .core_clk(core_clk), .rst_b(rst_b), .charger_direction_bit(charger_direction_bit),
  .connector_feed_n(connector_feed_n), .uv_below(uv_below), .oc_detect(oc_detect),
  .sc_detect(sc_detect), .ov_detect(ov_detect), .bus_presence_raw(bus_presence_raw),
  .bus_presence_irq(bus_presence_irq), .boost_en(boost_en), .iso_switch_en(iso_switch_en),
  .switch_fet_off(switch_fet_off), .uv_comp_en(uv_comp_en), .discharge_en(discharge_en),
  .soft_start_active(soft_start_active), .boost_fault_flag(boost_fault_flag));

// File: dv/obf_host_model.sv
// Host software model driving the register port
`timescale 1ns/10ps
module obf_host_model (
  // Clock
  input  wire logic                       core_clk,
  // Register port
  output logic      [obf_pkg::ADDR_W-1:0] reg_addr,
  output logic                            reg_wr,
  output logic                            reg_rd,
  output logic      [obf_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic [obf_pkg::DATA_W-1:0] reg_rdata
);
  initial begin
    reg_addr  = 9'h0;
    reg_wr    = 1'h0;
    reg_rd    = 1'h0;
    reg_wdata = 8'h0;
  end
  // Released lines show the inverse of the last value
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'h1;
    @(posedge core_clk);
    reg_wr    <= 1'h0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [8:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'h1;
    @(posedge core_clk);
    reg_rd   <= 1'h0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask
endmodule

// File: dv/otg_boost_enable_fault_ctl_tb.sv
// Self-checking bench for the boost enable and fault control
`timescale 1ns/10ps
module otg_boost_enable_fault_ctl_tb;
  localparam int         SSC  = 20;
  localparam logic [8:0] SREG = obf_pkg::STATE_CTL_OFFSET;
  localparam logic [8:0] DREG = obf_pkg::DSCH_CTL_OFFSET;
  logic       core_clk, rst_b, dir, feed_n, stby, uv_b, uv_h, stdy, oc, sc, ov, bp;
  logic       reg_wr, reg_rd, irq, boost, iso, fet, uvc, dsch, ss, flag;
  logic [8:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rv;
  int         bad_count, n_checks;
  obf_host_model u_host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  otg_boost_enable_fault_ctl #(.SOFT_START_CYCLES(SSC)) u_dut (
    .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .charger_direction_bit(dir), .connector_feed_n(feed_n), .standby_exit_pin(stby),
    .uv_below(uv_b), .uv_above_hyst(uv_h), .out_steady(stdy), .oc_detect(oc),
    .sc_detect(sc), .ov_detect(ov), .bus_presence_raw(bp), .bus_presence_irq(irq),
    .boost_en(boost), .iso_switch_en(iso), .switch_fet_off(fet), .uv_comp_en(uvc),
    .discharge_en(dsch), .soft_start_active(ss), .boost_fault_flag(flag));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic pins(input logic d, input logic n);
    @(posedge core_clk);
    dir    <= d;
    feed_n <= n;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic t_reset;
    u_host.rd(DREG, rv);
    chk("dsch_ctl", 8'h01, rv);
    u_host.rd(SREG, rv);
    chk("state_ctl", 8'h24, rv);
    u_host.wr(9'h1c7, 8'hff);
    u_host.rd(9'h1c7, rv);
    chk("unmapped", 8'h00, rv);
  endtask
  task automatic t_table;
    logic e;
    for (int i = 0; i < 32; i++) begin
      e = i[4] & ~i[3];
      u_host.wr(SREG, {5'h1c, i[2:0]});
      pins(i[4], i[3]);
      tick(3);
      chk("iso", e, iso);
      chk("boost", e | (i[2:0] == 3'h7), boost);
    end
    u_host.rd(SREG, rv);
    chk("state_rb", 8'h27, rv);
  endtask
  task automatic t_fault;
    pins(1'h0, 1'h1);
    u_host.wr(SREG, 8'h24);
    u_host.wr(SREG, 8'h27);
    tick(2);
    chk("turn_on", 8'h03, {flag, uvc});
    @(posedge core_clk);
    stdy <= 1'h1;
    tick(2);
    chk("ready", 8'h00, flag);
    @(posedge core_clk);
    uv_b <= 1'h1;
    tick(2);
    chk("uv", 8'h01, flag);
    @(posedge core_clk);
    uv_b <= 1'h0;
    uv_h <= 1'h1;
    oc   <= 1'h1;
    tick(2);
    chk("oc", 8'h03, {flag, fet});
    @(posedge core_clk);
    oc <= 1'h0;
    tick(2);
    chk("oc_gone", 8'h00, {flag, fet});
  endtask
  task automatic t_sc;
    int n;
    u_host.wr(SREG, 8'h24);
    @(posedge core_clk);
    sc <= 1'h1;
    pins(1'h1, 1'h0);
    tick(SSC / 2);
    chk("sc_mask", 8'h01, boost & ~flag);
    chk("ss_on", 8'h01, ss);
    for (n = SSC / 2; boost === 1'h1 && n < 4 * SSC; n++) tick(1);
    chk("sc_delay", 8'h01, n >= SSC && n <= SSC + 4);
    if (n >= 4 * SSC) tally_and_finish();
    @(posedge core_clk);
    sc <= 1'h0;
    tick(3);
    chk("sc_latch", 8'h04, {flag, boost, iso});
    chk("ss_off", 8'h00, ss);
    u_host.wr(SREG, 8'h27);
    tick(3);
    chk("sc_rearm", 8'h03, {flag, boost, iso});
  endtask
  task automatic t_ov;
    @(posedge core_clk);
    ov <= 1'h1;
    tick(3);
    @(posedge core_clk);
    ov <= 1'h0;
    tick(3);
    chk("ov_latch", 8'h04, {flag, boost, iso});
    u_host.wr(SREG, 8'h27);
    tick(3);
    chk("ov_rearm", 8'h03, {flag, boost, iso});
  endtask
  task automatic t_stby;
    logic [7:0] tv [3][3] = '{'{8'h3c, 8'h3f, 8'h01}, '{8'h1f, 8'h1f, 8'h01},
                              '{8'h27, 8'h24, 8'h00}};
    pins(1'h0, 1'h1);
    for (int i = 0; i < 3; i++) begin
      u_host.wr(SREG, tv[i][0]);
      @(posedge core_clk);
      stby <= 1'h1;
      @(posedge core_clk);
      stby <= 1'h0;
      u_host.rd(SREG, rv);
      chk("copy_rb", tv[i][1], rv);
      chk("copy_boost", tv[i][2], boost);
    end
  endtask
  task automatic t_dsch;
    u_host.wr(DREG, 8'h00);
    tick(2);
    chk("dsch_on", 8'h01, dsch);
    u_host.wr(SREG, 8'h27);
    tick(3);
    chk("dsch_boost", 8'h00, dsch);
    u_host.wr(DREG, 8'hff);
    u_host.rd(DREG, rv);
    chk("dsch_rb", 8'h01, rv);
  endtask
  task automatic t_irq;
    @(posedge core_clk);
    bp <= 1'h1;
    pins(1'h1, 1'h0);
    tick(2);
    chk("irq_mask", 8'h00, irq);
    pins(1'h1, 1'h1);
    tick(2);
    chk("irq_pass", 8'h01, irq);
  endtask
  initial begin
    core_clk = 1'h0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    {rst_b, dir, stby, uv_b, uv_h, stdy, oc, sc, ov, bp} = 10'h0;
    feed_n    = 1'h1;
    bad_count = 0;
    n_checks  = 0;
    repeat (5) @(posedge core_clk);
    rst_b <= 1'h1;
    t_reset();
    t_table();
    t_fault();
    t_sc();
    t_ov();
    t_stby();
    t_dsch();
    t_irq();
    tally_and_finish();
  end
endmodule
